// file: src/cmr_top.sv
// Purpose: Channel map registers, setup registers and a channel sequencer on APB.
// Assumes: Synchronous active-high reset; 10 MHz clock.
// Notes:   Outputs are registered; conversion timing is a fixed count.
`timescale 1ns/1ps

module cmr_top (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Converter routing.
  output logic [7:0]       pos_route,
  output logic [7:0]       neg_route,
  output logic [31:0]      setup_cfg,
  output logic [31:0]      filter_cfg,
  output logic [31:0]      offset_val,
  output logic [31:0]      gain_val,
  output logic [1:0]       active_ch,
  output logic             conv_busy
);

  typedef struct packed {
    logic [15:0]          map0;
    logic [15:0]          map1;
    logic [15:0]          map2;
    logic [15:0]          map3;
    logic [3:0][3:0][31:0] setup;
    cmr_pkg::cmr_seq_e    seq;
    logic [1:0]           ch;
    logic [7:0]           cnt;
    logic                 ready;
    logic [31:0]          rdata;
    logic                 err;
    logic [7:0]           pos;
    logic [7:0]           neg;
    logic [1:0]           sel;
    logic                 busy;
    logic [3:0][31:0]     hold;
  } cmr_state_s;

  cmr_state_s q;
  cmr_state_s d;
  logic [15:0] maps [cmr_pkg::NUM_CH];
  logic [3:0]  en;
  logic [9:0]  widx;
  logic        hit;
  logic [1:0]  nxt;
  logic        found;

  cmr_sel_if link ();

  cmr_route u_route (
    .sel (link)
  );

  assign maps[0] = q.map0;
  assign maps[1] = q.map1;
  assign maps[2] = q.map2;
  assign maps[3] = q.map3;
  assign en      = {q.map3[cmr_pkg::EN_BIT], q.map2[cmr_pkg::EN_BIT],
                    q.map1[cmr_pkg::EN_BIT], q.map0[cmr_pkg::EN_BIT]};
  assign widx    = paddr[11:2];

  // Active channel fields feed the route decoder.
  always_comb begin
    link.pos_code  = maps[q.ch][cmr_pkg::POS_LSB +: 5];
    link.neg_code  = maps[q.ch][cmr_pkg::NEG_LSB +: 5];
    link.setup_sel = maps[q.ch][cmr_pkg::SETUP_LSB +: 2];
    for (int i = 0; i < 4; i++) begin
      link.setups[i] = q.setup[i][0];
    end
  end

  // Next enabled channel after the current one, wrapping round.
  always_comb begin
    nxt   = q.ch;
    found = 1'b0;
    for (int k = 1; k <= 4; k++) begin
      if (!found && en[2'(q.ch + 2'(k))]) begin
        nxt   = 2'(q.ch + 2'(k));
        found = 1'b1;
      end
    end
  end

  always_comb begin
    d       = q;
    d.ready = 1'b0;
    d.err   = 1'b0;
    hit     = 1'b0;
    // APB access phase answered in one cycle.
    if (psel && penable && !q.ready) begin
      d.ready = 1'b1;
      d.rdata = 32'h0000_0000;
      case (widx[7:0])
        cmr_pkg::IDX_MAP0: begin
          hit = 1'b1;
          d.rdata = {16'h0000, q.map0};
          if (pwrite) d.map0 = pwdata[15:0] & cmr_pkg::MAP_WMASK;
        end
        cmr_pkg::IDX_MAP1: begin
          hit = 1'b1;
          d.rdata = {16'h0000, q.map1};
          if (pwrite) d.map1 = pwdata[15:0] & cmr_pkg::MAP_WMASK;
        end
        cmr_pkg::IDX_MAP2: begin
          hit = 1'b1;
          d.rdata = {16'h0000, q.map2};
          if (pwrite) d.map2 = pwdata[15:0] & cmr_pkg::MAP_WMASK;
        end
        cmr_pkg::IDX_MAP3: begin
          hit = 1'b1;
          d.rdata = {16'h0000, q.map3};
          if (pwrite) d.map3 = pwdata[15:0] & cmr_pkg::MAP_WMASK;
        end
        cmr_pkg::IDX_STATUS: begin
          hit = 1'b1;
          d.rdata = {24'h000000, q.busy, 1'b0, q.ch, en};
        end
        default: begin
          if (widx[7:4] == cmr_pkg::IDX_SETUP0[7:4]) begin
            hit = 1'b1;
            d.rdata = q.setup[widx[3:2]][widx[1:0]];
            if (pwrite) d.setup[widx[3:2]][widx[1:0]] = pwdata;
          end
        end
      endcase
      if (widx[9:8] != 2'b00) hit = 1'b0;
      if (!hit) begin
        d.err   = 1'b1;
        d.rdata = 32'h0000_0000;
      end
    end
    // Channel sequencer.
    case (q.seq)
      cmr_pkg::SEQ_IDLE: begin
        d.busy = 1'b0;
        if (en != 4'h0) d.seq = cmr_pkg::SEQ_PICK;
      end
      cmr_pkg::SEQ_PICK: begin
        if (en == 4'h0) begin
          d.seq = cmr_pkg::SEQ_IDLE;
        end else if (!en[q.ch]) begin
          d.ch = nxt;
        end else begin
          d.pos  = link.pos_onehot;
          d.neg  = link.neg_onehot;
          d.sel  = link.setup_sel;
          d.hold = q.setup[link.setup_sel];
          d.busy = !link.code_bad;
          d.cnt  = cmr_pkg::CONV_CYCLES;
          d.seq  = cmr_pkg::SEQ_CONV;
        end
      end
      cmr_pkg::SEQ_CONV: begin
        if (q.cnt > 8'h01) begin
          d.cnt = q.cnt - 8'h01;
        end else begin
          d.busy = 1'b0;
          d.ch   = nxt;
          d.seq  = cmr_pkg::SEQ_PICK;
        end
      end
      default: d.seq = cmr_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q       <= '0;
      q.map0  <= cmr_pkg::MAP0_RESET;
      q.map1  <= cmr_pkg::MAPN_RESET;
      q.map2  <= cmr_pkg::MAPN_RESET;
      q.map3  <= cmr_pkg::MAPN_RESET;
      q.seq   <= cmr_pkg::SEQ_IDLE;
    end else begin
      q <= d;
    end
  end

  assign pready     = q.ready;
  assign prdata     = q.rdata;
  assign pslverr    = q.err;
  assign pos_route  = q.pos;
  assign neg_route  = q.neg;
  assign active_ch  = q.ch;
  assign conv_busy  = q.busy;
  assign setup_cfg  = q.hold[0];
  assign filter_cfg = q.hold[1];
  assign offset_val = q.hold[2];
  assign gain_val   = q.hold[3];

endmodule // cmr_top

// file: src/cmr_pkg.sv
// Purpose: Constants and types for the channel map register slice.
// Assumes: APB with 32-bit data; one register per aligned word.
// Notes:   Offsets are register indices; byte address is four times the index.
package cmr_pkg;

  localparam int unsigned NUM_CH    = 4;
  localparam int unsigned NUM_SETUP = 4;

  // Register indices; byte address is four times the index.
  localparam logic [7:0]  IDX_MAP0   = 8'h10;
  localparam logic [7:0]  IDX_MAP1   = 8'h11;
  localparam logic [7:0]  IDX_MAP2   = 8'h12;
  localparam logic [7:0]  IDX_MAP3   = 8'h13;
  localparam logic [7:0]  IDX_SETUP0 = 8'h20;
  localparam logic [7:0]  IDX_STATUS = 8'h30;

  // Field positions.
  localparam int unsigned EN_BIT    = 15;
  localparam int unsigned RSV_BIT   = 14;
  localparam int unsigned SETUP_LSB = 12;
  localparam int unsigned POS_LSB   = 5;
  localparam int unsigned NEG_LSB   = 0;

  // Writable bits: enable, setup select, positive and negative selectors.
  localparam logic [15:0] MAP_WMASK   = 16'hb3ff;
  localparam logic [15:0] MAP0_RESET  = 16'h8001;
  localparam logic [15:0] MAPN_RESET  = 16'h0001;
  localparam logic [31:0] SETUP_RESET = 32'h0000_0000;

  // Analog input codes.
  localparam logic [4:0] SEL_ANALOG_INPUT_0 = 5'h00;
  localparam logic [4:0] SEL_ANALOG_INPUT_1 = 5'h01;
  localparam logic [4:0] SEL_ANALOG_INPUT_2 = 5'h02;
  localparam logic [4:0] SEL_ANALOG_INPUT_3 = 5'h03;
  localparam logic [4:0] SEL_ANALOG_INPUT_4 = 5'h04;
  localparam logic [4:0] SEL_REFP = 5'h15;
  localparam logic [4:0] SEL_REFN = 5'h16;

  // Conversion time per channel, in clock cycles.
  localparam int unsigned CONV_NS     = 20000;
  localparam int unsigned CLK_NS      = 100;
  localparam logic [7:0]  CONV_CYCLES = 8'((CONV_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_PICK = 2'b01,
    SEQ_CONV = 2'b10
  } cmr_seq_e;

endpackage : cmr_pkg

// file: src/cmr_sel_if.sv
// Purpose: Carries the active channel's routing from sequencer to selector.
// Assumes: One clock domain.
// Notes:   Setup registers are read out as an unpacked array.
`timescale 1ns/1ps
interface cmr_sel_if;
  logic [1:0]  setup_sel;
  logic [4:0]  pos_code;
  logic [4:0]  neg_code;
  logic [31:0] setups [cmr_pkg::NUM_SETUP];
  logic [7:0]  pos_onehot;
  logic [7:0]  neg_onehot;
  logic [31:0] setup_word;
  logic        code_bad;
  modport seq (output setup_sel, pos_code, neg_code, setups,
               input pos_onehot, neg_onehot, setup_word, code_bad);
  modport sel (input setup_sel, pos_code, neg_code, setups,
               output pos_onehot, neg_onehot, setup_word, code_bad);
endinterface : cmr_sel_if

// file: src/cmr_route.sv
// Purpose: Decodes input selector codes and picks the setup word.
// Assumes: Purely combinational.
// Notes:   Bits 0..6 are inputs 0..4, reference plus, reference minus.
`timescale 1ns/1ps
module cmr_route (
  // Routing link.
  cmr_sel_if.sel sel
);

  function automatic logic [7:0] decode(input logic [4:0] code);
    logic [7:0] r;
    r = 8'h00;
    case (code)
      cmr_pkg::SEL_ANALOG_INPUT_0: r = 8'h01;
      cmr_pkg::SEL_ANALOG_INPUT_1: r = 8'h02;
      cmr_pkg::SEL_ANALOG_INPUT_2: r = 8'h04;
      cmr_pkg::SEL_ANALOG_INPUT_3: r = 8'h08;
      cmr_pkg::SEL_ANALOG_INPUT_4: r = 8'h10;
      cmr_pkg::SEL_REFP: r = 8'h20;
      cmr_pkg::SEL_REFN: r = 8'h40;
      default:           r = 8'h00;
    endcase
    return r;
  endfunction

  always_comb begin
    sel.pos_onehot = decode(sel.pos_code);
    sel.neg_onehot = decode(sel.neg_code);
    sel.setup_word = sel.setups[sel.setup_sel];
    sel.code_bad   = (sel.pos_onehot == 8'h00) || (sel.neg_onehot == 8'h00);
  end

endmodule // cmr_route

// file: sim/cmr_checker.sv
// Purpose: Port assertions for the channel map slice.
// Assumes: One clock; synchronous active-high reset.
// Notes:   Bound to cmr_top from the bench top file.
`timescale 1ns/1ps
module cmr_checker (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst,
  // Bus.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Routing.
  input wire logic [7:0]  pos_route,
  input wire logic [7:0]  neg_route,
  input wire logic [1:0]  active_ch,
  input wire logic        conv_busy
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);
  logic [7:0] busy_q;
  always_ff @(posedge clk) begin
    busy_q <= (rst || !conv_busy) ? 8'h00 : busy_q + 8'h01;
  end
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready high too long");
  ready_time_a: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("pready late");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error read not zero");
  map_rsv_a: assert property (pready && paddr[11:4] == 8'h04 |-> (prdata & 32'hffff4c00) == 32'h0)
    else $error("reserved map bits set");
  reset_out_a: assert property ($fell(rst) |-> !pready && !conv_busy && active_ch == 2'h0)
    else $error("outputs not reset");
  route_hot_a: assert property (conv_busy |-> $onehot(pos_route) && $onehot(neg_route))
    else $error("route not one-hot");
  conv_len_a: assert property (busy_q <= 8'hc8)
    else $error("conversion too long");
  chan_hold_a: assert property (conv_busy && $past(conv_busy) |-> $stable(active_ch))
    else $error("channel changed mid conversion");
  cover property (pslverr);
  cover property (conv_busy && active_ch == 2'h3);
  cover property ($fell(conv_busy));
endmodule // cmr_checker

// file: sim/test_channel_map_register_slice.sv
// Purpose: Self-checking bench for the channel map slice.
// Assumes: APB master in the bench; model in arrays.
// Notes:   Random data from an xorshift generator.
`timescale 1ns/1ps
module test_channel_map_register_slice;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, conv_busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, setup_cfg, filter_cfg, offset_val, gain_val, rd, seed;
  logic [7:0]  pos_route, neg_route;
  logic [1:0]  active_ch;
  logic [31:0] mdl_map [4];
  logic [31:0] mdl_set [16];
  logic [4:0]  codes [7];
  int          n_errors, checked, i;

  cmr_top u_cmr_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pos_route(pos_route),
    .neg_route(neg_route), .setup_cfg(setup_cfg), .filter_cfg(filter_cfg),
    .offset_val(offset_val), .gain_val(gain_val), .active_ch(active_ch),
    .conv_busy(conv_busy));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] oh(input logic [4:0] c);
    if (c < 5'h05) return 8'h01 << c;
    if (c == 5'h15) return 8'h20;
    if (c == 5'h16) return 8'h40;
    return 8'h00;
  endfunction

  task automatic wrap_up();
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // One APB transfer, checked against the model.
  task automatic acc(input logic w, input logic [9:0] idx, input logic [31:0] d);
    logic e;
    logic me;
    int   k;
    me = !(idx inside {[10'h10:10'h13], [10'h20:10'h2f]});
    if (w && idx[9:2] == 8'h04) mdl_map[idx[1:0]] = d & 32'h0000b3ff;
    if (w && idx[9:4] == 6'h02) mdl_set[idx[3:0]] = d;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (k == 20) begin
      n_errors++;
      wrap_up();
    end
    chk({31'h0, me}, {31'h0, e});
    if (me) chk(32'h0, rd);
    if (!w && !me) chk(idx[5] ? mdl_set[idx[3:0]] : mdl_map[idx[1:0]], rd);
  endtask

  // Waits for a conversion on one channel and checks its routing.
  task automatic watch(input logic [1:0] ch);
    logic [15:0] m;
    int          k;
    m = mdl_map[ch][15:0];
    k = 0;
    while (!(conv_busy === 1'b1 && active_ch === ch) && k < 1000) begin
      @(posedge clk);
      k++;
    end
    if (k == 1000) begin
      n_errors++;
      wrap_up();
    end
    chk({24'h0, oh(m[9:5])}, {24'h0, pos_route});
    chk({24'h0, oh(m[4:0])}, {24'h0, neg_route});
    chk(mdl_set[{m[13:12], 2'b00}], setup_cfg);
    chk(mdl_set[{m[13:12], 2'b01}], filter_cfg);
    chk(mdl_set[{m[13:12], 2'b10}], offset_val);
    chk(mdl_set[{m[13:12], 2'b11}], gain_val);
  endtask

  initial begin
    seed = 32'h8430;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    n_errors = 0;
    checked = 0;
    mdl_map = '{32'h8001, 32'h1, 32'h1, 32'h1};
    mdl_set = '{default: 32'h0};
    codes = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h15, 5'h16};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 4; i++) acc(1'b0, 10'h10 + 10'(i), 32'h0);
    acc(1'b0, 10'h3ff, 32'h0);
    acc(1'b1, 10'h13, 32'h0000bfff);
    acc(1'b0, 10'h13, 32'h0);
    for (i = 0; i < 7; i++) begin
      acc(1'b1, 10'h12, {27'h0, codes[i]});
      acc(1'b0, 10'h12, 32'h0);
    end
    for (i = 0; i < 4; i++) begin
      acc(1'b1, 10'h13, 32'(i) << 12);
      acc(1'b0, 10'h13, 32'h0);
    end
    for (i = 0; i < 16; i++) begin
      acc(1'b1, 10'h20 + 10'(i), rnd());
      acc(1'b0, 10'h20 + 10'(i), 32'h0);
    end
    acc(1'b1, 10'h12, rnd());
    acc(1'b0, 10'h12, 32'h0);
    acc(1'b1, 10'h10, 32'h0);
    acc(1'b1, 10'h12, 32'ha056);
    acc(1'b1, 10'h13, 32'hb2a4);
    watch(2'h3);
    watch(2'h2);
    acc(1'b1, 10'h12, 32'hb056);
    watch(2'h3);
    watch(2'h2);
    wrap_up();
  end
endmodule // test_channel_map_register_slice

bind cmr_top cmr_checker u_cmr_checker (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .pos_route(pos_route), .neg_route(neg_route),
  .active_ch(active_ch), .conv_busy(conv_busy));
